/* hw/lbam_top.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "lbam_params.svh"

// Summary of operation
// RULE_01: judge input once every 128 ms cycle
// RULE_02: failed or erratic cycle adds one
// RULE_03: leak one per 1/2/4/8 clean cycles
// RULE_04: count saturates at programmed ceiling
// RULE_05: floor at zero; bad cycle restarts leak
// RULE_06: reaching upper threshold raises alarm
// RULE_07: falling to lower threshold clears alarm
module lbam_top
#(
    parameter int unsigned CYCLE_CLKS = `LBAM_CYCLE_CLKS
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // monitored input quality, asynchronous
    input  wire logic        ref_fail,
    input  wire logic        ref_erratic,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // alarm and interrupt
    output logic             activity_alarm,
    output logic             irq
);
    typedef struct packed {
        logic [1:0]  fail_sync;
        logic [1:0]  err_sync;
        logic [31:0] tmr;
        logic        tick;
        logic        seen_bad;
        logic        bad_cyc;
        logic [7:0]  ceiling;
        logic [7:0]  leak;
        logic [7:0]  upper;
        logic [7:0]  lower;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        aw_got;
        logic [11:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        alarm;
        logic        irq;
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
    } lbam_top_s;

    lbam_top_s s_q;
    lbam_top_s s_d;

    logic [7:0] level;
    logic       b_alarm;
    logic       raise_p;
    logic       clear_p;
    logic       sat_p;
    logic [2:0] ev;

    assign ev = {sat_p, clear_p, raise_p};

    lbam_bucket u_bucket
    (
        .clock       (clock),
        .rst         (rst),
        .tick        (s_q.tick),
        .bad         (s_q.bad_cyc),
        .ceiling     (s_q.ceiling),
        .leak_sel    (s_q.leak[`LBAM_LEAK_MSB:`LBAM_LEAK_LSB]),
        .upper       (s_q.upper),
        .lower       (s_q.lower),
        .level       (level),
        .alarm       (b_alarm),
        .raise_pulse (raise_p),
        .clear_pulse (clear_p),
        .sat_pulse   (sat_p)
    );

    // register index from a byte address; low two bits ignored
    function automatic logic [9:0] idx(input logic [11:0] a);
        idx = a[11:2];
    endfunction

    // readback mux; unmapped reads give zero with slverr
    function automatic logic [32:0] rd(input lbam_top_s s, input logic [9:0] i, input logic [7:0] lv,
                                       input logic al);
        rd = {1'b0, 32'h0000_0000};
        if (i == 10'(`LBAM_IDX_CEILING))
            rd[7:0] = s.ceiling;
        else if (i == 10'(`LBAM_IDX_LEAK))
            rd[7:0] = s.leak;
        else if (i == 10'(`LBAM_IDX_UPPER))
            rd[7:0] = s.upper;
        else if (i == 10'(`LBAM_IDX_LOWER))
            rd[7:0] = s.lower;
        else if (i == 10'(`LBAM_IDX_STATUS))
            rd[2:0] = s.status;
        else if (i == 10'(`LBAM_IDX_MASK))
            rd[2:0] = s.mask;
        else if (i == 10'(`LBAM_IDX_LEVEL))
            rd[8:0] = {al, lv};
        else
            rd[32] = 1'b1;
    endfunction

    // whole-block next state
    always_comb
    begin
        logic [9:0]  wi;
        logic [32:0] r;
        logic [2:0]  w1c;
        wi  = '0;
        r   = '0;
        w1c = 3'h0;
        s_d = s_q;

        // pins pass two flops before use
        s_d.fail_sync = {s_q.fail_sync[0], ref_fail};
        s_d.err_sync  = {s_q.err_sync[0], ref_erratic};

        // monitoring cycle timebase; any bad sample latches for the cycle
        s_d.tick = 1'b0;
        if (s_q.tmr >= CYCLE_CLKS - 1)
        begin
            s_d.tmr      = 32'h0000_0000;
            s_d.tick     = 1'b1; // RULE_01
            s_d.bad_cyc  = s_q.seen_bad | s_q.fail_sync[1] | s_q.err_sync[1];
            s_d.seen_bad = 1'b0;
        end
        else
        begin
            s_d.tmr      = s_q.tmr + 32'h0000_0001;
            s_d.seen_bad = s_q.seen_bad | s_q.fail_sync[1] | s_q.err_sync[1]; // RULE_01
        end

        // write channels taken in either order
        if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid)
        begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid)
        begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got)
        begin
            wi          = idx(s_q.aw_addr);
            s_d.aw_got  = 1'b0;
            s_d.w_got   = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = 2'h0;
            if (s_q.w_strb[0])
            begin
                if (wi == 10'(`LBAM_IDX_CEILING))
                    s_d.ceiling = s_q.w_data[7:0];
                else if (wi == 10'(`LBAM_IDX_LEAK))
                    s_d.leak = {6'h00, s_q.w_data[1:0]};
                else if (wi == 10'(`LBAM_IDX_UPPER))
                    s_d.upper = s_q.w_data[7:0];
                else if (wi == 10'(`LBAM_IDX_LOWER))
                    s_d.lower = s_q.w_data[7:0];
                else if (wi == 10'(`LBAM_IDX_STATUS))
                    w1c = s_q.w_data[2:0];
                else if (wi == 10'(`LBAM_IDX_MASK))
                    s_d.mask = s_q.w_data[2:0];
                else if (wi != 10'(`LBAM_IDX_LEVEL))
                    s_d.bresp = 2'h2;
            end
        end
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;

        // read: answer one cycle after the address
        if (s_axi_arvalid && !s_q.rvalid)
        begin
            r          = rd(s_q, idx(s_axi_araddr), level, b_alarm);
            s_d.rvalid = 1'b1;
            s_d.rdata  = r[31:0];
            s_d.rresp  = r[32] ? 2'h2 : 2'h0;
        end
        else if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;

        // sticky events, set wins over write-one-clear
        s_d.status = (s_q.status & ~w1c) | ev;
        s_d.irq    = |(s_d.status & s_q.mask);
        s_d.alarm  = b_alarm; // RULE_06 RULE_07
        // readies from the next state, so each bus port leaves a flop
        s_d.aw_rdy = !s_d.aw_got && !s_d.bvalid;
        s_d.w_rdy  = !s_d.w_got && !s_d.bvalid;
        s_d.ar_rdy = !s_d.rvalid;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q         <= '0;
            s_q.ceiling <= `LBAM_RST_CEILING;
            s_q.leak    <= `LBAM_RST_LEAK;
            s_q.upper   <= `LBAM_RST_UPPER;
            s_q.lower   <= `LBAM_RST_LOWER;
            s_q.aw_rdy  <= 1'b1;
            s_q.w_rdy   <= 1'b1;
            s_q.ar_rdy  <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign s_axi_awready  = s_q.aw_rdy;
    assign s_axi_wready   = s_q.w_rdy;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_arready  = s_q.ar_rdy;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;
    assign activity_alarm = s_q.alarm;
    assign irq            = s_q.irq;
endmodule // lbam_top

/* shared/lbam_params.svh */
`ifndef LBAM_PARAMS_SVH
`define LBAM_PARAMS_SVH

// register indices as printed; byte address is four times the index
`define LBAM_IDX_CEILING      8'h52
`define LBAM_IDX_LEAK         8'h53
`define LBAM_IDX_UPPER        8'h50
`define LBAM_IDX_LOWER        8'h51
`define LBAM_IDX_STATUS       8'h60
`define LBAM_IDX_MASK         8'h61
`define LBAM_IDX_LEVEL        8'h62
`define LBAM_IDX_CTRL         8'h63

// reset values
`define LBAM_RST_CEILING      8'h08
`define LBAM_RST_LEAK         8'h01
`define LBAM_RST_UPPER        8'h06
`define LBAM_RST_LOWER        8'h04
`define LBAM_RST_MASK         8'h00
`define LBAM_RST_CTRL         8'h00

// field positions
`define LBAM_LEAK_LSB         0
`define LBAM_LEAK_MSB         1
`define LBAM_ST_RAISE         0
`define LBAM_ST_CLEAR         1
`define LBAM_ST_SAT           2
`define LBAM_LVL_ALARM        8
`define LBAM_CTRL_START       0

// timing: one monitoring cycle
`define LBAM_CYCLE_MS         128
`define LBAM_CLK_MHZ          100
`define LBAM_CYCLE_CLKS       (`LBAM_CYCLE_MS * 1000 * `LBAM_CLK_MHZ)

`endif

/* shared/lbam_pkg.sv */
package lbam_pkg;
    typedef enum logic [1:0] {LBAM_AXI_IDLE, LBAM_AXI_WRESP, LBAM_AXI_RDATA} lbam_axi_e;
    typedef logic [7:0] lbam_byte_t;
endpackage

/* hw/lbam_bucket.sv */
`timescale 1ns/10ps
`include "lbam_params.svh"

// leaky bucket accumulator with saturation, leak divider and alarm hysteresis
module lbam_bucket
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // one pulse per monitoring cycle and its verdict
    input  wire logic               tick,
    input  wire logic               bad,
    // configuration
    input  wire lbam_pkg::lbam_byte_t ceiling,
    input  wire logic [1:0]         leak_sel,
    input  wire lbam_pkg::lbam_byte_t upper,
    input  wire lbam_pkg::lbam_byte_t lower,
    // state
    output logic [7:0]              level,
    output logic                    alarm,
    output logic                    raise_pulse,
    output logic                    clear_pulse,
    output logic                    sat_pulse
);
    typedef struct packed {
        logic [7:0] level;
        logic [2:0] clean;
        logic       alarm;
        logic       raise_p;
        logic       clear_p;
        logic       sat_p;
    } lbam_bkt_s;

    lbam_bkt_s s_q;
    lbam_bkt_s s_d;
    logic [3:0] span;

    // clean cycles per leak step: 1, 2, 4 or 8
    assign span = 4'h1 << leak_sel; // RULE_03

    // next-state of the bucket
    always_comb
    begin
        s_d         = s_q;
        s_d.raise_p = 1'b0;
        s_d.clear_p = 1'b0;
        s_d.sat_p   = 1'b0;
        if (tick)
        begin
            if (bad)
            begin
                s_d.clean = 3'h0; // RULE_05
                if (s_q.level < ceiling)
                    s_d.level = s_q.level + 8'h01; // RULE_02
                else
                begin
                    s_d.level = ceiling; // RULE_04
                    s_d.sat_p = 1'b1;
                end
            end
            else if ({1'b0, s_q.clean} + 4'h1 >= span)
            begin
                s_d.clean = 3'h0; // RULE_03
                if (s_q.level != 8'h00)
                    s_d.level = s_q.level - 8'h01; // RULE_05
            end
            else
                s_d.clean = s_q.clean + 3'h1;
        end
        // hysteresis; checked on the new level
        if (!s_q.alarm && s_d.level >= upper)
        begin
            s_d.alarm   = 1'b1; // RULE_06
            s_d.raise_p = 1'b1;
        end
        else if (s_q.alarm && s_d.level <= lower)
        begin
            s_d.alarm   = 1'b0; // RULE_07
            s_d.clear_p = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level       = s_q.level;
    assign alarm       = s_q.alarm;
    assign raise_pulse = s_q.raise_p;
    assign clear_pulse = s_q.clear_p;
    assign sat_pulse   = s_q.sat_p;
endmodule // lbam_bucket

/* bench/lbam_monitor.sv */
`timescale 1ns/10ps
// handshake spacing and alarm timing seen at the top ports
module lbam_monitor
#(
    parameter int unsigned CYCLE_CLKS = 16
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // monitored input
    input wire logic ref_fail,
    input wire logic ref_erratic,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // alarm and interrupt
    input wire logic activity_alarm,
    input wire logic irq
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    int unsigned since_bad_q;
    int unsigned since_chg_q;
    logic        alarm_q;

    // saturating ages, so long quiet spans never wrap
    always_ff @(posedge clock)
    begin
        since_bad_q <= (ref_fail || ref_erratic) ? 32'h0 : since_bad_q + {31'h0, ~&since_bad_q};
        since_chg_q <= rst ? 32'hFFFF_FFFF : (activity_alarm != alarm_q) ? 32'h0 : since_chg_q + {31'h0, ~&since_chg_q};
        alarm_q     <= activity_alarm;
    end

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    AST_RESET_IDLE: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !activity_alarm && !irq)
        else $error("outputs not idle after reset");
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WR_HOLD: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_ALARM_RISE: assert property ($rose(activity_alarm) |-> since_bad_q <= CYCLE_CLKS + 8)
        else $error("alarm rose with no recent bad sample");
    AST_ALARM_FALL: assert property ($fell(activity_alarm) |-> since_bad_q >= CYCLE_CLKS)
        else $error("alarm fell without a clean cycle");
    AST_ALARM_PACE: assert property ((activity_alarm != alarm_q) |-> since_chg_q >= CYCLE_CLKS - 1)
        else $error("alarm moved twice in one cycle");
endmodule // lbam_monitor

bind lbam_top lbam_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) u_lbam_monitor
(
    .clock(clock), .rst(rst), .ref_fail(ref_fail), .ref_erratic(ref_erratic),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .activity_alarm(activity_alarm), .irq(irq)
);

/* bench/lbam_tb.sv */
`timescale 1ns/10ps
`include "lbam_params.svh"
// random bad and clean cycles against a bench model of the bucket
module testbench;
    localparam int CC = 32; // short cycle keeps the run brief
    logic        clock = 1'b0, rst = 1'b1, ref_fail = 1'b0, ref_erratic = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, seed = 32'h0E05, rd_d, x, rdata_w;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, activity_alarm, irq, alm, vp, v;
    logic [1:0]  bresp, rresp, rsp;
    logic [2:0]  st;
    logic [7:0]  ix_t [6] = '{8'h52, 8'h53, 8'h50, 8'h51, 8'h61, 8'h62};
    logic [7:0]  ex_t [6] = '{8'h08, 8'h01, 8'h06, 8'h04, 8'h00, 8'h00};
    int          err_count = 0, n_tests = 0, cyc = 0, t0, lvl, ceil, code, lc, msk, s, b;

    initial forever #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    lbam_top #(.CYCLE_CLKS(CC)) i_dut
    (
        .clock(clock), .rst(rst), .ref_fail(ref_fail), .ref_erratic(ref_erratic),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata_w), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .activity_alarm(activity_alarm), .irq(irq)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] ix, input logic [31:0] d);
        awaddr <= {2'b00, ix, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge clock); // strobes never reassigned in the same step
    endtask

    task automatic rd(input logic [7:0] ix);
        araddr <= {2'b00, ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rd_d = rdata_w;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask

    // bench model of one monitoring cycle
    task automatic upd(input logic bad);
        logic na;
        if (bad)
        begin
            if (lvl >= ceil) st[2] = 1'b1;
            lvl = (lvl >= ceil) ? ceil : lvl + 1;
            lc = 0;
        end
        else
        begin
            lc++;
            if (lc == (1 << code))
            begin
                lc = 0;
                if (lvl > 0) lvl--;
            end
        end
        na = (lvl >= `LBAM_RST_UPPER) ? 1'b1 : ((lvl <= `LBAM_RST_LOWER) ? 1'b0 : alm);
        st = st | {1'b0, !na && alm, na && !alm};
        alm = na;
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 6; i++)
        begin
            rd(ix_t[i]);
            chk("reset value", {24'h0, ex_t[i]}, rd_d);
        end
        rd(8'h70);
        chk("unmapped read", 32'h2, {rd_d[29:0], rsp});
        wr(8'h70, 32'hFF);
        chk("unmapped write", 32'h2, {30'h0, rsp});
        // a forced bad input locates the cycle boundary
        ref_fail <= 1'b1;
        for (int i = 0; i < 40 && rd_d[7:0] !== 8'h01; i++) rd(`LBAM_IDX_LEVEL);
        t0 = cyc;
        {lvl, ceil, code, lc, msk, alm, st, vp} = {32'd1, 32'd8, 32'd1, 32'd0, 32'd0, 1'b0, 3'h0, 1'b1};
        for (int k = 0; k < 160; k++)
        begin
            while (cyc < t0 + 8 + k * CC) @(posedge clock);
            rd(`LBAM_IDX_LEVEL);
            chk("level", {23'h0, alm, lvl[7:0]}, rd_d);
            chk("alarm pin", {31'h0, alm}, {31'h0, activity_alarm});
            chk("irq", {31'h0, |(st & msk[2:0])}, {31'h0, irq});
            s = k % 20;
            b = k / 20;
            if (s == 0)
            begin
                ceil = rnd() % 8 + 5; // above lower threshold: a clamp never clears the alarm
                code = (b / 2) % 4;
                wr(`LBAM_IDX_CEILING, 32'(ceil));
                wr(`LBAM_IDX_LEAK, 32'(code));
            end
            if (s == 1)
            begin
                msk = rnd() % 8;
                wr(`LBAM_IDX_MASK, 32'(msk));
            end
            if (s == 19)
            begin
                rd(`LBAM_IDX_STATUS);
                chk("status", {29'h0, st}, rd_d);
                wr(`LBAM_IDX_STATUS, 32'h7);
                st = 3'h0;
            end
            x = rnd();
            v = (s == 0) || (x[10:8] < ((b % 2) ? 3'h6 : 3'h1));
            ref_fail <= v && x[0];
            ref_erratic <= v && !x[0];
            upd(vp | v);
            vp = v;
        end
        close_out();
    end

    // cut a hang short well past the expected run length
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        close_out();
    end
endmodule // testbench
